// *** src/clr_pkg.sv ***
package clr_pkg;
  // lane line states as {dp, dn}
  localparam logic [1:0]  LP_STOP      = 2'h3;
  localparam logic [1:0]  LP_RQST      = 2'h1;
  localparam logic [1:0]  LP_BRDG      = 2'h0;
  localparam logic [7:0]  HS_SYNC      = 8'hb8;
  localparam logic [5:0]  SHORT_DT_MAX = 6'h0f;
  localparam logic [15:0] CRC_POLY     = 16'h8408;
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam logic [1:0]  HDR_LAST     = 2'h3;
  // lane count selection
  localparam logic [1:0]  LANES_1      = 2'h0;
  localparam logic [1:0]  LANES_2      = 2'h1;
  // ecc parity masks over header bits 23..0, parity bit 0 last
  localparam logic [5:0][23:0] ECC_MASK = {24'heffc00, 24'hdf03f0,
    24'hb8e38e, 24'h749a6d, 24'hf2555b, 24'hf12cb7};

  typedef enum logic [1:0] {
    LS_STOP = 2'h0,
    LS_RQST = 2'h1,
    LS_HS   = 2'h3
  } clr_lane_e;

  typedef enum logic [1:0] {
    PS_HDR = 2'h0,
    PS_PAY = 2'h1,
    PS_CRC = 2'h3
  } clr_parse_e;

  typedef struct packed {
    logic [7:0] data;
    logic       sop;
    logic       eop;
  } clr_item_s;

  typedef struct packed {
    logic [7:0]  di;
    logic [15:0] word;
  } clr_short_s;
endpackage : clr_pkg

// *** src/clr_lane_receiver.sv ***
`timescale 1ns/10ps
// Behaviour
// - target only, lanes are never driven
// - escape mode sequences are not decoded
// - each lane tracked as low-power or high-speed
// - high-speed entered after stop, request, bridge
// - high-speed held until stop is seen
// - termination enable while lane is high-speed
// - bridge line state kept through the burst
// - clock lane uses same state tracking
// - input selects continuous or gated clock lane
// - continuous mode flags clock lane leaving high-speed
// - one, two or four data lanes
// - data type up to 0x0f is short
// - short packets as sync markers, long carry payload
// - long header, payload, then checksum footer
// - header ecc corrects one data bit, flags two bits or a parity bit
// - payload checksum compared with footer
// - start and sync errors reported per lane
module clr_lane_receiver
  import clr_pkg::*;
#(
  parameter int LANES = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // configuration
  input  wire logic             cont_clk_mode,
  input  wire logic [1:0]       lane_cfg,
  // lane pins: lines {dp,dn}, lane 4 is the clock lane
  input  wire logic [9:0]       lp_lines,
  input  wire logic             link_clk,
  input  wire logic [31:0]      hs_bytes,
  output logic      [4:0]       term_en,
  // payload stream
  output clr_pkg::clr_item_s    out_item,
  output logic                  out_valid,
  input  wire logic             out_ready,
  // short packets and status pulses
  output clr_pkg::clr_short_s   short_pkt,
  output logic                  short_valid,
  output logic                  ecc_corr,
  output logic                  ecc_err,
  output logic                  crc_err,
  output logic      [3:0]       sot_err,
  output logic      [3:0]       sot_sync_err,
  output logic                  clk_mode_err
);
  import clr_pkg::*;

  // lane slots are hard wired, so refuse any other count at elaboration
  if (LANES != 4)
  begin : g_lanes_chk
    $error("only four lane slots supported");
  end

  function automatic logic [5:0] ecc_calc(input logic [23:0] d);
    logic [5:0] p;
    p = '0;
    for (int k = 0; k < 6; k++) p[k] = ^(d & ECC_MASK[k]);
    return p;
  endfunction : ecc_calc

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c;
    for (int k = 0; k < 8; k++)
      r = (r[0] ^ b[k]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction : crc_byte

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [9:0]  lp_s1, lp_s2, lp_s3, lp_f;
  logic [2:0]  lk_s;
  logic        lk_f;
  logic [31:0] hb_s1, hb_s2, hb_s3;
  wire  [9:0]  lp_next = (lp_s2 == lp_s3) ? lp_s3 : lp_f;
  wire         lk_next = (lk_s[1] == lk_s[2]) ? lk_s[2] : lk_f;
  wire         lk_edge = lk_next & ~lk_f;

  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      lp_s1 <= {5{LP_STOP}};
      lp_s2 <= {5{LP_STOP}};
      lp_s3 <= {5{LP_STOP}};
      lp_f  <= {5{LP_STOP}};
      lk_s  <= '0;
      lk_f  <= 1'b0;
      hb_s1 <= '0;
      hb_s2 <= '0;
      hb_s3 <= '0;
    end
    else
    begin
      lp_s1 <= lp_lines;
      lp_s2 <= lp_s1;
      lp_s3 <= lp_s2;
      lp_f  <= lp_next;
      lk_s  <= {lk_s[1:0], link_clk};
      lk_f  <= lk_next;
      hb_s1 <= hs_bytes;
      hb_s2 <= hb_s1;
      hb_s3 <= hb_s2;
    end

  // ****************************************
  // lane state tracking
  // ****************************************
  // no lane output exists: pins are listen only
  // escape entry (stop to 10) is simply not followed
  clr_lane_e  st     [5];
  logic [3:0] found, tried;
  wire  [3:0] act = (lane_cfg == LANES_1) ? 4'h1 :
                    (lane_cfg == LANES_2) ? 4'h3 : 4'hf;

  for (genvar i = 0; i < 5; i++)
  begin : g_lane
    wire [1:0] lp = lp_f[2*i +: 2];
    clr_lane_e nxt;
    always_comb
    begin
      nxt = st[i];
      case (st[i])
        LS_STOP: if (lp == LP_RQST) nxt = LS_RQST;
        LS_RQST: if (lp == LP_BRDG) nxt = LS_HS;
                 else if (lp != LP_RQST) nxt = LS_STOP;
        LS_HS:   if (lp == LP_STOP) nxt = LS_STOP;
        default: nxt = LS_STOP;
      endcase
    end
    always_ff @(posedge clock or negedge arst_n)
      if (!arst_n) st[i] <= LS_STOP;
      else         st[i] <= nxt;
    assign term_en[i] = (st[i] == LS_HS);
  end

  for (genvar i = 0; i < 4; i++)
  begin : g_sync
    wire [7:0] b    = hb_s3[8*i +: 8];
    wire [7:0] x    = b ^ HS_SYNC;
    wire       one  = (x != 8'h00) && ((x & (x - 8'h01)) == 8'h00);
    wire       look = act[i] && term_en[i] && lk_edge && !tried[i];
    always_ff @(posedge clock or negedge arst_n)
      if (!arst_n)
      begin
        found[i]        <= 1'b0;
        tried[i]        <= 1'b0;
        sot_err[i]      <= 1'b0;
        sot_sync_err[i] <= 1'b0;
      end
      else
      begin
        // first byte of burst checked against the sync pattern
        if (!term_en[i])
        begin
          found[i] <= 1'b0;
          tried[i] <= 1'b0;
        end
        else if (look)
        begin
          tried[i] <= 1'b1;
          found[i] <= (x == 8'h00) || one;
        end
        sot_err[i]      <= look && one;
        sot_sync_err[i] <= look && (x != 8'h00) && !one;
      end
  end

  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) clk_mode_err <= 1'b0;
    else         clk_mode_err <= cont_clk_mode && term_en[4] &&
                                 (lp_f[9:8] == LP_STOP);

  // ****************************************
  // lane merge
  // ****************************************
  // the emitter has eight clocks per link byte; a stall longer than
  // that overwrites the held word
  logic [31:0] mrg_data;
  logic [2:0]  mrg_left;
  logic [1:0]  mrg_sel;
  logic        pa_ready;
  wire         burst_ok = ((found & act) == act);
  wire         mrg_load = lk_edge && burst_ok;
  wire         emit     = (mrg_left != 3'h0) && pa_ready;
  wire  [7:0]  eb       = mrg_data[{mrg_sel, 3'h0} +: 8];
  wire  [2:0]  act_n    = (lane_cfg == LANES_1) ? 3'h1 :
                          (lane_cfg == LANES_2) ? 3'h2 : 3'h4;

  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      mrg_data <= '0;
      mrg_left <= '0;
      mrg_sel  <= '0;
    end
    else if (mrg_load)
    begin
      mrg_data <= hb_s3;
      mrg_left <= act_n;
      mrg_sel  <= 2'h0;
    end
    else if (emit)
    begin
      mrg_left <= mrg_left - 3'h1;
      mrg_sel  <= mrg_sel + 2'h1;
    end

  // ****************************************
  // packet parser
  // ****************************************
  clr_parse_e  ps;
  logic [1:0]  hidx;
  logic [23:0] hdr;
  logic [15:0] wc_left, crc, crc_rx;
  logic        drop, first, cidx, buf_in_ready;
  wire  [23:0] hraw  = hdr;
  wire  [5:0]  syn   = ecc_calc(hraw) ^ eb[5:0];
  logic [23:0] hfix;
  logic        fixed;
  always_comb
  begin
    hfix  = hraw;
    fixed = 1'b0;
    for (int k = 0; k < 24; k++)
      if (syn != 6'h0 && syn == {ECC_MASK[5][k], ECC_MASK[4][k],
          ECC_MASK[3][k], ECC_MASK[2][k], ECC_MASK[1][k], ECC_MASK[0][k]})
      begin
        hfix[k] = ~hraw[k];
        fixed   = 1'b1;
      end
  end
  wire hdr_end  = emit && !drop && ps == PS_HDR && hidx == HDR_LAST;
  wire bad      = (syn != 6'h0) && !fixed;
  wire is_short = hfix[5:0] <= SHORT_DT_MAX;
  wire pay_push = emit && !drop && ps == PS_PAY;
  wire burst_end = !term_en[0];
  assign pa_ready = (ps != PS_PAY) || buf_in_ready;

  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      ps <= PS_HDR; hidx <= '0; hdr <= '0; wc_left <= '0;
      crc <= CRC_INIT; crc_rx <= '0; cidx <= 1'b0; drop <= 1'b0;
      first <= 1'b0; short_pkt <= '0; short_valid <= 1'b0;
      ecc_corr <= 1'b0; ecc_err <= 1'b0; crc_err <= 1'b0;
    end
    else
    begin
      short_valid <= hdr_end && !bad && is_short;
      ecc_corr    <= hdr_end && fixed;
      ecc_err     <= hdr_end && bad;
      crc_err     <= 1'b0;
      if (burst_end)
      begin
        ps <= PS_HDR; hidx <= '0; drop <= 1'b0;
      end
      else if (emit && !drop)
        case (ps)
          PS_HDR:
          begin
            hidx <= hidx + 2'h1;
            hdr  <= {eb, hdr[23:8]};
            if (hidx == HDR_LAST)
            begin
              hidx      <= '0;
              hdr       <= hfix;
              short_pkt <= '{di: hfix[7:0], word: hfix[23:8]};
              crc       <= CRC_INIT;
              first     <= 1'b1;
              cidx      <= 1'b0;
              wc_left   <= hfix[23:8];
              if (bad) drop <= 1'b1;
              else if (!is_short)
                ps <= (hfix[23:8] == 16'h0) ? PS_CRC : PS_PAY;
            end
          end
          PS_PAY:
          begin
            crc     <= crc_byte(crc, eb);
            first   <= 1'b0;
            wc_left <= wc_left - 16'h1;
            if (wc_left == 16'h1) ps <= PS_CRC;
          end
          PS_CRC:
          begin
            cidx   <= 1'b1;
            crc_rx <= {eb, crc_rx[15:8]};
            if (cidx)
            begin
              ps      <= PS_HDR;
              crc_err <= ({eb, crc_rx[15:8]} != crc);
            end
          end
          default: ps <= PS_HDR;
        endcase
    end

  // ****************************************
  // two-entry output buffer
  // ****************************************
  clr_item_s  bq [2];
  logic [1:0] bcnt;
  logic       wp, rp;
  wire        b_push = pay_push && buf_in_ready;
  wire        b_pop  = out_valid && out_ready;
  assign buf_in_ready = (bcnt != 2'h2);
  assign out_valid    = (bcnt != 2'h0);
  assign out_item     = bq[rp];

  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      bq[0] <= '0; bq[1] <= '0; bcnt <= '0; wp <= 1'b0; rp <= 1'b0;
    end
    else
    begin
      if (b_push)
      begin
        bq[wp] <= '{data: eb, sop: first, eop: (wc_left == 16'h1)};
        wp     <= ~wp;
      end
      if (b_pop) rp <= ~rp;
      bcnt <= bcnt + {1'b0, b_push} - {1'b0, b_pop};
    end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence seq_rqst(int n);
    st[n] == LS_RQST && lp_f[2*n +: 2] == LP_BRDG;
  endsequence

  chk_hs_entry_data: assert property (
    $rose(term_en[0]) |-> $past(st[0]) == LS_RQST)
    else $error("data lane entered high speed without request");
  chk_hs_entry_clk: assert property (
    seq_rqst(4) |=> term_en[4])
    else $error("clock lane missed high speed entry");
  chk_hs_hold: assert property (
    term_en[1] && lp_f[3:2] != LP_STOP |=> term_en[1])
    else $error("lane left high speed without stop");
  chk_term_cause: assert property (
    $rose(term_en[2]) |-> $past(lp_f[5:4]) == LP_BRDG)
    else $error("termination enabled without bridge state");
  chk_cont_clk: assert property (
    cont_clk_mode && term_en[4] && lp_f[9:8] == LP_STOP
    |=> clk_mode_err ##1 !term_en[4])
    else $error("clock lane exit not flagged");
  chk_short_type: assert property (
    short_valid |-> short_pkt.di[5:4] == 2'h0)
    else $error("short packet with long data type");
  chk_sync_fail: assert property (
    sot_sync_err[0] |-> !found[0] [*2])
    else $error("lane aligned after sync failure");
  chk_merge_count: assert property (
    mrg_load && lane_cfg == LANES_2 |=> mrg_left == 3'h2)
    else $error("two lane merge count wrong");
  chk_buffer_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_item))
    else $error("buffered word lost under stall");
endmodule : clr_lane_receiver

// *** tb/clr_sensor_model.sv ***
`timescale 1ns/10ps
// ********************************
// sensor side of the lane link
// ********************************
module clr_sensor_model
  import clr_pkg::*;
(
  // pacing clock
  input  wire logic        clock,
  // lanes toward the receiver
  output logic      [9:0]  lp_lines,
  output logic             link_clk,
  output logic      [31:0] hs_bytes
);
  initial
  begin
    lp_lines = {5{LP_STOP}};
    link_clk = 1'b0;
    hs_bytes = 32'h0;
  end

  // all five lanes move together, to whatever state the caller passes, escape entry included
  task automatic lp_hold(input logic [1:0] st, input int n);
    @(posedge clock);
    lp_lines <= {5{st}};
    repeat (n - 1) @(posedge clock);
  endtask : lp_hold

  // link clock stands still outside bursts; idle lanes keep changing
  task automatic burst(input logic [7:0] pl[$], input int nl,
                       input logic [7:0] sync);
    logic [31:0] w;
    lp_hold(LP_STOP, 6);
    lp_hold(LP_RQST, 6);
    lp_hold(LP_BRDG, 6);
    // byte changes with the falling link edge: eight clocks a period
    @(posedge clock);
    for (int e = -1; e < pl.size() / nl; e++)
    begin
      w = ~hs_bytes;
      for (int l = 0; l < nl; l++)
        w[8*l +: 8] = (e < 0) ? sync : pl[e*nl+l];
      hs_bytes <= w;
      repeat (4) @(posedge clock);
      link_clk <= 1'b1;
      repeat (4) @(posedge clock);
      link_clk <= 1'b0;
    end
    repeat (16) @(posedge clock);
    hs_bytes <= ~hs_bytes;
    lp_hold(LP_STOP, 6);
  endtask : burst
endmodule : clr_sensor_model

// *** tb/tb.sv ***
`timescale 1ns/10ps
// ********************************
// receiver regression bench
// ********************************
module tb;
  import clr_pkg::*;
  logic        clock;
  logic        arst_n;
  logic        cont_clk_mode;
  logic [1:0]  lane_cfg;
  logic [9:0]  lp_lines;
  logic        link_clk;
  logic [31:0] hs_bytes;
  logic [4:0]  term_en;
  clr_item_s   out_item;
  logic        out_valid;
  logic        out_ready;
  clr_short_s  short_pkt;
  logic        short_valid;
  logic        ecc_corr;
  logic        ecc_err;
  logic        crc_err;
  logic [3:0]  sot_err;
  logic [3:0]  sot_sync_err;
  logic        clk_mode_err;
  logic [2:0]  rdy_cnt;
  int          error_cnt;
  int          num_checks;
  int          n_short, n_corr, n_eerr, n_crc, n_sot, n_sync, n_cme, n_hs;
  clr_short_s  last_short;
  logic [3:0]  sot_seen;
  logic [3:0]  sync_seen;
  clr_item_s   items[$];
  logic [7:0]  pk[$];

  clr_lane_receiver #(.LANES(4)) u_clr_lane_receiver (
    .clock, .arst_n, .cont_clk_mode, .lane_cfg, .lp_lines, .link_clk,
    .hs_bytes, .term_en, .out_item, .out_valid, .out_ready, .short_pkt,
    .short_valid, .ecc_corr, .ecc_err, .crc_err, .sot_err, .sot_sync_err,
    .clk_mode_err);

  clr_sensor_model u_clr_sensor_model (.clock, .lp_lines, .link_clk,
    .hs_bytes);

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // receiver stalls 3 of every 8 cycles to exercise the buffer
  always @(posedge clock)
  begin
    rdy_cnt <= rdy_cnt + 3'h1;
    out_ready <= rdy_cnt > 3'h2;
    if (out_valid === 1'b1 && out_ready === 1'b1) items.push_back(out_item);
    if (short_valid === 1'b1) n_short++;
    if (short_valid === 1'b1) last_short = short_pkt;
    if (ecc_corr === 1'b1) n_corr++;
    if (ecc_err === 1'b1) n_eerr++;
    if (crc_err === 1'b1) n_crc++;
    if (sot_err !== 4'h0) n_sot++;
    sot_seen = sot_seen | sot_err;
    sync_seen = sync_seen | sot_sync_err;
    if (sot_sync_err !== 4'h0) n_sync++;
    if (clk_mode_err === 1'b1) n_cme++;
    if (term_en[0] === 1'b1 && term_en[4] === 1'b1) n_hs++;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic rst(input logic [1:0] cfg, input logic cont);
    @(posedge clock);
    arst_n <= 1'b0;
    lane_cfg <= cfg;
    cont_clk_mode <= cont;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask : rst

  // header with parity taken before any deliberate flip
  task automatic add_pkt(input logic [7:0] di, input logic [15:0] wc,
                         input logic [23:0] flip, input logic [15:0] crcx);
    logic [23:0] h;
    logic [7:0]  e;
    logic [7:0]  pay[$];
    logic [15:0] c;
    h = {wc, di};
    e = 8'h00;
    for (int i = 0; i < 6; i++) e[i] = ^(h & ECC_MASK[i]);
    h = h ^ flip;
    pk = {pk, h[7:0], h[15:8], h[23:16], e};
    if (di[5:0] > SHORT_DT_MAX)
    begin
      for (int k = 0; k < wc; k++) pay.push_back(8'ha0 + k[7:0]);
      c = CRC_INIT;
      foreach (pay[i])
        for (int b = 0; b < 8; b++)
          c = (c >> 1) ^ ((c[0] ^ pay[i][b]) ? CRC_POLY : 16'h0);
      c = c ^ crcx;
      pk = {pk, pay, c[7:0], c[15:8]};
    end
  endtask : add_pkt

  task automatic run(input int nl, input logic [7:0] sync);
    {n_short, n_corr, n_eerr, n_crc, n_sot, n_sync, n_cme, n_hs} = '0;
    items.delete();
    sot_seen = 4'h0;
    sync_seen = 4'h0;
    u_clr_sensor_model.burst(pk, nl, sync);
    repeat (10) @(posedge clock);
    pk.delete();
  endtask : run

  task automatic t_entry;
    n_hs = 0;
    u_clr_sensor_model.lp_hold(LP_BRDG, 8);
    u_clr_sensor_model.lp_hold(2'h2, 8);
    u_clr_sensor_model.lp_hold(LP_BRDG, 8);
    u_clr_sensor_model.lp_hold(LP_STOP, 8);
    chk("hs_no_request", 0, n_hs);
    add_pkt(8'h00, 16'h0001, 24'h0, 16'h0);
    run(4, HS_SYNC);
    chk("term_en_burst", 1, n_hs > 20);
    chk("term_en_stop", 0, term_en);
  endtask : t_entry

  task automatic t_lanes;
    for (int i = 0; i < 3; i++)
    begin
      rst(i[1:0], 1'b0);
      add_pkt(8'h0f, 16'h5a3c, 24'h0, 16'h0);
      add_pkt(8'h10, 16'h0006, 24'h0, 16'h0);
      run(1 << i, HS_SYNC);
      chk("short_count", 1, n_short);
      chk("short_pkt", {8'h0f, 16'h5a3c}, last_short);
      chk("payload_count", 6, items.size());
      foreach (items[k])
        chk("payload", {8'ha0 + k[7:0], k == 0, k == 5}, items[k]);
      chk("pulses", 0, n_crc + n_eerr + n_corr + n_sot + n_sync + n_cme);
    end
  endtask : t_lanes

  task automatic t_faults;
    rst(2'h2, 1'b0);
    add_pkt(8'h10, 16'h0006, 24'h0, 16'h0101);
    run(4, HS_SYNC);
    chk("crc_err", 1, n_crc);
    add_pkt(8'h01, 16'h00f0, 24'h000400, 16'h0);
    run(4, HS_SYNC);
    chk("ecc_corr", 1, n_corr);
    chk("corrected", {8'h01, 16'h00f0}, last_short);
    add_pkt(8'h01, 16'h00f0, 24'h000c00, 16'h0);
    run(4, HS_SYNC);
    chk("ecc_err", 1, n_eerr);
    chk("ecc_drop", 0, n_short);
    add_pkt(8'h02, 16'h0001, 24'h0, 16'h0);
    run(4, HS_SYNC ^ 8'h01);
    chk("sot_err", 4'hf, sot_seen);
    chk("sot_kept", 1, n_short);
    add_pkt(8'h02, 16'h0001, 24'h0, 16'h0);
    run(4, 8'h00);
    chk("sot_sync_err", 4'hf, sync_seen);
    chk("sync_drop", 0, n_short);
  endtask : t_faults

  task automatic t_cont;
    rst(2'h2, 1'b1);
    add_pkt(8'h03, 16'h0002, 24'h0, 16'h0);
    run(4, HS_SYNC);
    chk("clk_mode_err", 1, n_cme != 0);
  endtask : t_cont

  initial
  begin
    arst_n = 1'b0;
    lane_cfg = 2'h2;
    cont_clk_mode = 1'b0;
    out_ready = 1'b0;
    rdy_cnt = 3'h0;
    rst(2'h2, 1'b0);
    t_entry();
    $display("test entry done");
    t_lanes();
    $display("test lanes done");
    t_faults();
    $display("test faults done");
    t_cont();
    $display("test cont done");
    end_of_test();
  end

  // about twenty times the expected run length
  initial
  begin
    #(20000 * 40);
    error_cnt++;
    end_of_test();
  end
endmodule : tb
